// ===== rtl/lbo_pkg.sv
package lbo_pkg;

  // Symbol group layout
  localparam int LBO_SYM_W = 10;
  localparam int LBO_SYMS = 4;
  localparam int LBO_GRP_W = LBO_SYM_W * LBO_SYMS;
  localparam int LBO_GRP_BITS_LAST = LBO_GRP_W - 1;

  // Serial bit rate: one bit every LBO_SER_DIV clocks
  localparam int LBO_SER_DIV = 4;
  localparam logic [1:0] LBO_DIV_LAST = 2'(LBO_SER_DIV - 1);

  // Reconfiguration address decode
  localparam int LBO_OFF_W_NARROW = 10;
  localparam int LBO_OFF_W_WIDE = 11;
  localparam int LBO_RC_AW = 14;
  localparam int LBO_AXI_AW = LBO_RC_AW + 2;
  localparam int LBO_DATA_W = 32;

  // Implemented words per channel space
  localparam int LBO_SPACE_WORDS = 16;
  localparam int LBO_OFF_CTRL = 0;
  localparam int LBO_OFF_STAT = 1;
  localparam logic [31:0] LBO_CTRL_RST = 32'h0000_0001;
  localparam int LBO_CTRL_EN_BIT = 0;

  // Status word layout
  localparam int LBO_STAT_GRP_LSB = 16;
  localparam int LBO_STAT_CNT_LSB = 1;
  localparam int LBO_STAT_BUSY_BIT = 0;

  // AXI responses
  localparam logic [1:0] LBO_RESP_OKAY = 2'h0;
  localparam logic [1:0] LBO_RESP_SLVERR = 2'h2;

  // Buffer depth
  localparam logic [1:0] LBO_BUF_DEPTH = 2'h2;

  // Serializer states
  typedef enum logic [1:0] {
    LBO_SER_IDLE = 2'b01,
    LBO_SER_SHIFT = 2'b10
  } lbo_ser_t;

endpackage

// ===== rtl/lbo_lane.sv
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
module lbo_lane
  import lbo_pkg::*;
#(
  parameter bit BIT_REVERSE = 1'b0,
  parameter bit RECONFIG_EN = 1'b1,
  parameter bit DEBUG_EN = 1'b0,
  parameter bit SHARED = 1'b1,
  parameter bit WIDE_OFFSET = 1'b0,
  parameter int LANES = 4,
  localparam int OFF_W = WIDE_OFFSET ? LBO_OFF_W_WIDE : LBO_OFF_W_NARROW
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Encoded symbol groups in
  input wire logic [LBO_GRP_W-1:0] grp_data,
  input wire logic grp_valid,
  output logic grp_ready,
  // Serial lane out
  output logic ser_bit,
  output logic ser_valid,
  output logic ser_first,
  // AXI4-Lite shared reconfiguration port
  input wire logic [LBO_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [LBO_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [LBO_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [LBO_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Debug endpoint, driven by the JTAG host side
  input wire logic dbg_req,
  input wire logic dbg_write,
  input wire logic [LBO_RC_AW-1:0] dbg_addr,
  input wire logic [LBO_DATA_W-1:0] dbg_wdata,
  output logic dbg_ack,
  output logic [LBO_DATA_W-1:0] dbg_rdata,
  // Per-channel reconfiguration ports
  input wire logic [LANES-1:0] pc_req,
  input wire logic [LANES-1:0] pc_write,
  input wire logic [LANES*OFF_W-1:0] pc_addr,
  input wire logic [LANES*LBO_DATA_W-1:0] pc_wdata,
  output logic [LANES-1:0] pc_ack,
  output logic [LANES*LBO_DATA_W-1:0] pc_rdata
);
  // Build-time decode options
  localparam int CH_W = (LANES > 1) ? $clog2(LANES) : 0;
  localparam int ENT = LANES * LBO_SPACE_WORDS;
  localparam bit RC_ON = RECONFIG_EN;
  localparam bit DBG_ON = RECONFIG_EN && DEBUG_EN;
  // Several channels plus debug cannot work unshared, so sharing is forced
  localparam bit SH_EFF = SHARED || (DEBUG_EN && LANES > 1);
  localparam bit AXI_ON = RC_ON && SH_EFF;
  localparam bit PC_ON = RC_ON && !SH_EFF;
  typedef struct packed {
    logic [1:0][LBO_GRP_W-1:0] buf_d;
    logic [1:0] buf_cnt;
    logic in_ready;
    lbo_ser_t st;
    logic [LBO_GRP_W-1:0] sh;
    logic [5:0] bits_left;
    logic [1:0] div;
    logic ser_bit;
    logic ser_valid;
    logic ser_first;
    logic [15:0] grp_cnt;
    logic [ENT-1:0][LBO_DATA_W-1:0] mem;
    logic aw_hold;
    logic [LBO_RC_AW-1:0] aw_addr;
    logic w_hold;
    logic [LBO_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [LBO_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic dbg_ack;
    logic [LBO_DATA_W-1:0] dbg_rdata;
    logic [LANES-1:0] pc_ack;
    logic [LANES*LBO_DATA_W-1:0] pc_rdata;
  } lbo_st_t;
  // Reset image; channel control words start with the lane enabled
  function automatic lbo_st_t init_st();
    lbo_st_t r;
    r = '0;
    for (int c = 0; c < LANES; c++)
      r.mem[c*LBO_SPACE_WORDS+LBO_OFF_CTRL] = LBO_CTRL_RST;
    r.st = LBO_SER_IDLE;
    r.in_ready = 1'b1;
    r.awready = 1'b1;
    r.wready = 1'b1;
    r.arready = 1'b1;
    return r;
  endfunction
  localparam lbo_st_t ST_RST = init_st();
  // Word address to {hit, entry}; offset low, channel above it
  function automatic logic [8:0] dec(input logic [LBO_RC_AW-1:0] a, input logic en);
    int off;
    int ch;
    logic [LBO_RC_AW-1:0] up;
    logic hit;
    off = int'(a) & ((1 << OFF_W) - 1);
    ch = int'(a >> OFF_W) & ((1 << CH_W) - 1);
    up = a >> (OFF_W + CH_W);
    hit = en && (up == '0) && (off < LBO_SPACE_WORDS);
    return {hit, 8'(ch * LBO_SPACE_WORDS + off)};
  endfunction
  // Byte-lane merge for AXI writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (b[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction
  function automatic logic is_stat(input logic [7:0] idx);
    return (int'(idx) % LBO_SPACE_WORDS) == LBO_OFF_STAT;
  endfunction
  lbo_st_t s;
  lbo_st_t nxt_s;
  logic [LBO_GRP_W-1:0] rev_grp;
  logic [LBO_GRP_W-1:0] ord_grp;
  logic [31:0] stat_word;
  // Per-symbol bit reversal; symbol order within the group never changes
  for (genvar k = 0; k < LBO_SYMS; k++)
  begin : g_sym
    for (genvar i = 0; i < LBO_SYM_W; i++)
    begin : g_bit
      assign rev_grp[k*LBO_SYM_W+i] = s.buf_d[0][k*LBO_SYM_W+LBO_SYM_W-1-i];
    end
  end
  // Shifting LSB first out of this vector sends symbol 0 first
  assign ord_grp = BIT_REVERSE ? rev_grp : s.buf_d[0];
  // Lane status seen at every channel's status offset
  assign stat_word = {s.grp_cnt, 13'h0000, s.buf_cnt, s.ser_valid};
  always_comb
  begin
    logic tick;
    logic load;
    logic push;
    logic [8:0] d;
    logic [7:0] idx;
    int slot;
    nxt_s = s;
    tick = (s.div == 2'h0);
    load = 1'b0;
    push = grp_valid && s.in_ready;
    d = '0;
    idx = '0;
    slot = 0;
    // Bit-rate divider; the lane shifts only on its pulse
    nxt_s.div = tick ? LBO_DIV_LAST : 2'(s.div - 2'h1);
    nxt_s.ser_first = tick ? 1'b0 : s.ser_first;
    // Serializer
    unique case (s.st)
      LBO_SER_IDLE:
      begin
        if (tick && s.buf_cnt != 2'h0 && s.mem[LBO_OFF_CTRL][LBO_CTRL_EN_BIT])
        begin
          load = 1'b1;
        end
      end
      LBO_SER_SHIFT:
      begin
        if (tick)
        begin
          if (s.bits_left != 6'h00)
          begin
            // Whole symbol before the next, ten bits each
            nxt_s.ser_bit = s.sh[0];
            nxt_s.sh = s.sh >> 1;
            nxt_s.bits_left = 6'(s.bits_left - 6'h01);
          end
          else if (s.buf_cnt != 2'h0 && s.mem[LBO_OFF_CTRL][LBO_CTRL_EN_BIT])
          begin
            load = 1'b1; // Back to back, no gap between groups
          end
          else
          begin
            nxt_s.st = LBO_SER_IDLE;
            nxt_s.ser_valid = 1'b0;
          end
        end
      end
    endcase
    // Group load: first bit leaves on this same pulse
    if (load)
    begin
      nxt_s.st = LBO_SER_SHIFT;
      nxt_s.ser_bit = ord_grp[0];
      nxt_s.sh = ord_grp >> 1;
      nxt_s.bits_left = 6'(LBO_GRP_BITS_LAST);
      nxt_s.ser_valid = 1'b1;
      nxt_s.ser_first = 1'b1;
      nxt_s.grp_cnt = 16'(s.grp_cnt + 16'h0001);
    end
    // Two-entry buffer; ready drops when full so no group is lost
    nxt_s.buf_cnt = load ? 2'(s.buf_cnt - 2'h1) : s.buf_cnt;
    if (load)
    begin
      nxt_s.buf_d[0] = s.buf_d[1];
    end
    if (push)
    begin
      slot = int'(nxt_s.buf_cnt);
      nxt_s.buf_d[slot[0]] = grp_data;
      nxt_s.buf_cnt = 2'(nxt_s.buf_cnt + 2'h1);
    end
    nxt_s.in_ready = (nxt_s.buf_cnt != LBO_BUF_DEPTH);
    // AXI address and data captured in either order
    if (s_axi_awvalid && s.awready)
    begin
      nxt_s.aw_hold = 1'b1;
      nxt_s.aw_addr = s_axi_awaddr[LBO_AXI_AW-1:2];
      nxt_s.awready = 1'b0;
    end
    if (s_axi_wvalid && s.wready)
    begin
      nxt_s.w_hold = 1'b1;
      nxt_s.w_data = s_axi_wdata;
      nxt_s.w_strb = s_axi_wstrb;
      nxt_s.wready = 1'b0;
    end
    // Write commits once both halves are held
    if (s.aw_hold && s.w_hold && !s.bvalid)
    begin
      d = dec(s.aw_addr, AXI_ON);
      idx = d[7:0];
      if (d[8] && !is_stat(idx))
      begin
        nxt_s.mem[idx] = merge(s.mem[idx], s.w_data, s.w_strb);
      end
      nxt_s.bresp = d[8] ? LBO_RESP_OKAY : LBO_RESP_SLVERR;
      nxt_s.bvalid = 1'b1;
      nxt_s.aw_hold = 1'b0;
      nxt_s.w_hold = 1'b0;
    end
    if (s.bvalid && s_axi_bready)
    begin
      nxt_s.bvalid = 1'b0;
      nxt_s.awready = 1'b1;
      nxt_s.wready = 1'b1;
    end
    // AXI read, answered one cycle after the address is taken
    if (s_axi_arvalid && s.arready)
    begin
      d = dec(s_axi_araddr[LBO_AXI_AW-1:2], AXI_ON);
      idx = d[7:0];
      nxt_s.arready = 1'b0;
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = d[8] ? LBO_RESP_OKAY : LBO_RESP_SLVERR;
      nxt_s.rdata = !d[8] ? '0 : (is_stat(idx) ? stat_word : s.mem[idx]);
    end
    if (s.rvalid && s_axi_rready)
    begin
      nxt_s.rvalid = 1'b0;
      nxt_s.arready = 1'b1;
    end
    // Debug endpoint: same decode, one-cycle acknowledge
    nxt_s.dbg_ack = 1'b0;
    if (DBG_ON && dbg_req)
    begin
      d = dec(dbg_addr, 1'b1);
      idx = d[7:0];
      nxt_s.dbg_ack = 1'b1;
      nxt_s.dbg_rdata = '0;
      if (d[8] && dbg_write && !is_stat(idx))
      begin
        nxt_s.mem[idx] = dbg_wdata;
      end
      else if (d[8] && !dbg_write)
      begin
        nxt_s.dbg_rdata = is_stat(idx) ? stat_word : s.mem[idx];
      end
    end
    // Independent per-channel ports, slices packed channel 0 lowest
    nxt_s.pc_ack = '0;
    for (int c = 0; c < LANES; c++)
    begin
      if (PC_ON && pc_req[c])
      begin
        d = dec(LBO_RC_AW'(pc_addr[c*OFF_W +: OFF_W]), 1'b1);
        idx = 8'(c * LBO_SPACE_WORDS + int'(d[7:0]));
        nxt_s.pc_ack[c] = 1'b1;
        nxt_s.pc_rdata[c*LBO_DATA_W +: LBO_DATA_W] = '0;
        if (d[8] && pc_write[c] && !is_stat(idx))
        begin
          nxt_s.mem[idx] = pc_wdata[c*LBO_DATA_W +: LBO_DATA_W];
        end
        else if (d[8] && !pc_write[c])
        begin
          nxt_s.pc_rdata[c*LBO_DATA_W +: LBO_DATA_W] =
            is_stat(idx) ? stat_word : s.mem[idx];
        end
      end
    end
  end
  // Single state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= ST_RST;
    end
    else
    begin
      s <= nxt_s;
    end
  end
  // Outputs straight from the state register
  assign grp_ready = s.in_ready;
  assign ser_bit = s.ser_bit;
  assign ser_valid = s.ser_valid;
  assign ser_first = s.ser_first;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign dbg_ack = s.dbg_ack;
  assign dbg_rdata = s.dbg_rdata;
  assign pc_ack = s.pc_ack;
  assign pc_rdata = s.pc_rdata;
endmodule

// ===== sim/lbo_lane_checker.sv
module lbo_chk
  import lbo_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial lane
  input wire logic ser_bit,
  input wire logic ser_valid,
  input wire logic ser_first,
  // Register port
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LBO_DATA_W-1:0] s_axi_rdata,
  // Debug host
  input wire logic dbg_req,
  input wire logic dbg_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Serial framing
  first_mark_a: assert property ($rose(ser_valid) |-> ser_first)
    else $error("group start not marked");
  // The start mark stands for the whole first bit cell, four clocks
  first_pulse_a: assert property ($rose(ser_first) |=> ser_first [*3] ##1 !ser_first)
    else $error("group start mark not one cell");
  bit_hold_a: assert property ($rose(ser_first) |=> $stable(ser_bit) [*3])
    else $error("bit cell too short");
  group_len_a: assert property (ser_first |-> ##160 (ser_first || !ser_valid))
    else $error("group not forty cells");
  // Register port and debug handshakes
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  dbg_ack_a: assert property (dbg_req |=> dbg_ack)
    else $error("debug request not acknowledged");
  cover property (ser_first ##160 ser_first);
  cover property (s_axi_bvalid && !s_axi_awready);
  cover property (dbg_ack);
endmodule

bind lbo_lane lbo_chk chk_u (.aclk, .aresetn, .ser_bit, .ser_valid, .ser_first, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .dbg_req, .dbg_ack);

// ===== sim/lbo_sink.sv
module lbo_sink
(
  // Clock
  input wire logic aclk,
  // Serial lane from the device
  input wire logic ser_bit,
  input wire logic ser_valid,
  input wire logic ser_first,
  // Groups in arrival order
  output logic [39:0] words [0:3],
  output int count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [39:0] sh;
  logic [1:0] ph;
  int idx = 40;
  initial count = 0;
  // Sample the first cell on each clock of its start mark, then each later cell once, four clocks apart; wraps after four groups
  always @(posedge aclk)
  begin
    if (ser_first)
    begin
      sh[0] = ser_bit;
      idx = 1;
      ph = 2'h1;
    end
    else if (ser_valid && idx < 40)
    begin
      if (ph == 2'h0)
      begin
        sh[idx] = ser_bit;
        idx++;
      end
      ph++;
      if (idx == 40)
      begin
        words[count[1:0]] <= sh;
        count <= count + 1;
      end
    end
  end
endmodule

// ===== sim/tb_lbo_lane.sv
module tb_lbo_lane
  import lbo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [39:0] G0 = 40'h3A_5C96_0F1E;
  localparam logic [39:0] G1 = 40'hC5_A369_F0E1;
  logic aclk, aresetn, grp_valid, grp_ready, ser_bit, ser_valid, ser_first;
  logic r_bit, r_valid, r_first, dbg_req, dbg_write, dbg_ack;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb, pc_req, pc_write, pc_ack;
  logic [LBO_AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, dbg_wdata, dbg_rdata;
  logic [LBO_RC_AW-1:0] dbg_addr;
  logic [39:0] grp_data, pc_addr, nw [0:3], rw [0:3];
  logic [127:0] pc_wdata, pc_rdata;
  int nn, rn, mismatches, compares;

  // Debug on with four lanes: the shared port must win over SHARED off
  lbo_lane #(.BIT_REVERSE(1'b0), .DEBUG_EN(1'b1), .SHARED(1'b0)) dut_u (.aclk, .aresetn,
    .grp_data, .grp_valid, .grp_ready, .ser_bit, .ser_valid, .ser_first, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dbg_req, .dbg_write, .dbg_addr,
    .dbg_wdata, .dbg_ack, .dbg_rdata, .pc_req, .pc_write, .pc_addr, .pc_wdata, .pc_ack,
    .pc_rdata);
  // Reversed twin sees the same traffic; only its lane is observed
  lbo_lane #(.BIT_REVERSE(1'b1), .DEBUG_EN(1'b1), .SHARED(1'b0)) dut_r (.aclk, .aresetn,
    .grp_data, .grp_valid, .grp_ready(), .ser_bit(r_bit), .ser_valid(r_valid),
    .ser_first(r_first), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .dbg_req, .dbg_write, .dbg_addr,
    .dbg_wdata, .dbg_ack(), .dbg_rdata(), .pc_req, .pc_write, .pc_addr, .pc_wdata, .pc_ack(),
    .pc_rdata());
  lbo_sink snk_n (.aclk, .ser_bit, .ser_valid, .ser_first, .words(nw), .count(nn));
  lbo_sink snk_r (.aclk, .ser_bit(r_bit), .ser_valid(r_valid), .ser_first(r_first),
    .words(rw), .count(rn));

  // 250 MHz clock
  always #2 aclk = ~aclk;

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Controller stand-in: address and data leave on their own readies
  task automatic axw(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar;
    ar = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      ar = ar && !s_axi_arready;
      s_axi_arvalid <= ar;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One-cycle request, answer sampled the cycle after it is taken
  task automatic dbg(input logic wr, input logic [13:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge aclk);
    dbg_req <= 1'b1;
    dbg_write <= wr;
    dbg_addr <= a;
    dbg_wdata <= d;
    @(posedge aclk);
    dbg_req <= 1'b0;
    @(posedge aclk);
    q = dbg_rdata;
    chk(40'(dbg_ack), 40'h1);
  endtask

  task automatic push(input logic [39:0] g);
    @(posedge aclk);
    grp_data <= g;
    grp_valid <= 1'b1;
    do
      @(posedge aclk);
    while (!grp_ready);
    grp_valid <= 1'b0;
  endtask

  // Each symbol flipped end for end, symbol order kept
  function automatic logic [39:0] rev(input logic [39:0] g);
    for (int i = 0; i < 40; i++)
      rev[i] = g[i - i % 10 + 9 - i % 10];
  endfunction

  function automatic logic [15:0] ba(input int ch, input int off);
    return 16'(((ch << LBO_OFF_W_NARROW) + off) * 4);
  endfunction

  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog, well past the expected run of some 400 cycles
  initial
  begin
    #20000;
    mismatches++;
    report_and_stop;
  end

  // Test sequence
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    {aclk, aresetn, grp_valid, grp_data, dbg_req, dbg_write, dbg_addr, dbg_wdata,
      s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr,
      s_axi_araddr, s_axi_wdata, s_axi_wstrb, pc_req, pc_write, pc_addr, pc_wdata} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(40'(grp_ready), 40'h1);
    axr(ba(0, 0), d, r);
    chk(40'(d), 40'(LBO_CTRL_RST));
    axw(ba(2, 0), 32'h0000_00A5, r);
    chk(40'(r), 40'(LBO_RESP_OKAY));
    axr(ba(2, 0), d, r);
    chk(40'(d), 40'hA5);
    axr(ba(1, 0), d, r);
    chk(40'(d), 40'(LBO_CTRL_RST));
    axr(ba(3, LBO_SPACE_WORDS), d, r);
    chk(40'({r, d}), {6'h0, LBO_RESP_SLVERR, 32'h0});
    $display("decode test done");
    axw(ba(0, 0), 32'h0, r);
    push(G0);
    push(G1);
    repeat (2) @(posedge aclk);
    chk(40'(grp_ready), 40'h0);
    axw(ba(0, LBO_OFF_STAT), 32'hFFFF_FFFF, r);
    axr(ba(0, LBO_OFF_STAT), d, r);
    chk(40'(d[2:0]), 40'h4);
    axw(ba(0, 0), 32'h1, r);
    do
      @(posedge aclk);
    while (nn < 2 || rn < 2);
    chk(nw[0], G0);
    chk(nw[1], G1);
    chk(rw[0], rev(G0));
    chk(rw[1], rev(G1));
    $display("lane order test done");
    dbg(1'b1, 14'h0C00, 32'h0000_005A, d);
    axr(ba(3, 0), d, r);
    chk(40'(d), 40'h5A);
    dbg(1'b0, 14'h0800, 32'h0, d);
    chk(40'(d), 40'hA5);
    // Per-channel writes to offset 2 must be ignored while sharing is forced
    @(posedge aclk);
    pc_req <= 4'hF;
    pc_write <= 4'hF;
    pc_addr <= {4{10'h002}};
    pc_wdata <= {4{32'h0000_00C3}};
    @(posedge aclk);
    pc_req <= 4'h0;
    @(posedge aclk);
    chk(40'(pc_ack), 40'h0);
    chk(pc_rdata[39:0], 40'h0);
    axr(ba(1, 2), d, r);
    chk(40'(d), 40'h0);
    $display("debug test done");
    report_and_stop;
  end
endmodule
